// ---- pwm_cfg_pkg.sv ----
// Constants for the PWM sync, PLL and supply switch configuration bank
package pwm_cfg_pkg;
  // ==========================================================
  // Register addresses (byte offsets)
  localparam logic [7:0] ADDR_TEMP_FILT = 8'h69;
  localparam logic [7:0] ADDR_PWRLINE = 8'h6a;
  localparam logic [7:0] ADDR_SLOWDIV_HI = 8'h6b;
  localparam logic [7:0] ADDR_SYNC_CTRL = 8'h6c;
  localparam logic [7:0] ADDR_PLL_CTRL = 8'h6d;
  localparam logic [7:0] ADDR_PLL_MODE = 8'h70;
  localparam logic [7:0] ADDR_STATUS = 8'h71;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_TEMP_FILT = 8'h00;
  localparam logic [7:0] RST_PWRLINE = 8'h00;
  localparam logic [7:0] RST_SLOWDIV_HI = 8'h00;
  localparam logic [7:0] RST_SYNC_CTRL = 8'h00;
  localparam logic [7:0] RST_PLL_CTRL = 8'h00;
  localparam logic [7:0] RST_PLL_MODE = 8'h00;
  // ==========================================================
  // Field positions
  localparam int GAIN_LSB = 4;
  localparam int FILT_LSB = 0;
  localparam int THERM_EN_BIT = 7;
  localparam int NTYPE_BIT = 6;
  localparam int SS_LSB = 4;
  localparam int ILIM_LSB = 2;
  localparam int GATE_LSB = 0;
  localparam int SYNC_EN_BIT = 7;
  localparam int PWM_SYNC_BIT = 6;
  localparam int CNT_RST_BIT = 5;
  localparam int DIVLO_LSB = 0;
  localparam int RSEL_LSB = 6;
  localparam int SEL_DIV_BIT = 5;
  localparam int PLL_EN_BIT = 4;
  localparam int PREDIV_LSB = 0;
  localparam int SYNC_TYPE_BIT = 4;
  localparam int RES_LSB = 0;
  // ==========================================================
  // Filter lengths in PWM generator clock cycles
  localparam logic [8:0] FILT_LEN [16] = '{
    9'd5, 9'd10, 9'd20, 9'd40, 9'd60, 9'd80, 9'd100, 9'd140,
    9'd180, 9'd220, 9'd260, 9'd300, 9'd340, 9'd380, 9'd420, 9'd460};
  // Soft-start times in ms
  localparam logic [5:0] SS_MS [4] = '{6'd5, 6'd10, 6'd20, 6'd50};
  // Gate currents in uA: p-type normal, n-type fault recovery
  localparam logic [11:0] GATE_P_UA [4] = '{
    12'd55, 12'd110, 12'd220, 12'd440};
  localparam logic [11:0] GATE_N_UA [4] = '{
    12'd300, 12'd500, 12'd1000, 12'd2200};
  // Current limit in A for codes 10 and 11
  localparam logic [3:0] ILIM_A [4] = '{4'd0, 4'd0, 4'd6, 4'd8};
  // Clock timing
  localparam int CLK_HZ = 20000000;
  localparam int MS_PER_S = 1000;
  // PWM clock source encodings
  localparam logic [1:0] SRC_OSC = 2'b00;
  localparam logic [1:0] SRC_PLL_OSC = 2'b01;
  localparam logic [1:0] SRC_PLL_SYNC = 2'b10;
endpackage : pwm_cfg_pkg

// ---- pwm_sync_pll_config_bank.sv ----
// Configuration bank for thermal dimming, supply switch and PWM sync/PLL
//
// Overview of operation
// - Upper nibble gain scales LED current reduction from temperature reading.
// - Low nibble picks comparator filter length, 5 to 460 PWM cycles.
// - Only filtered comparator drives short detect and boost downscaling.
// - Switch type bit: clear is p-channel, set is n-channel drive.
// - Soft-start code 00..11 gives 5, 10, 20, 50 ms.
// - Current limit code 10 is 6 A, 11 is 8 A.
// - Gate current 55..440 uA p-type; n-type 0.3..2.2 mA recovery only.
// - Slow divider: high eight bits one register, low five the next.
// - Frame sync input ignored unless sync enable bit set.
// - PWM sync bit set: PWM output divided by slow divider feeds phase detector.
// - Counter-reset bit restarts PWM generator on each pre-divided sync rising edge.
// - Slow divider coefficient codes select 16, 32, 64, 128.
// - Divider select: clear slow external, set fast internal compensation.
// - PLL disabled uses oscillator directly; enabled derives from osc or sync.
// - Pre-divider divides frame sync by 1 to 16.
// - Resolution field sets PLL multiplier for 5, 10, 20, 40 MHz.
// - Sync-type bit tells PLL line-rate or frame-rate sync input.
`timescale 1ns/100ps
`default_nettype none
module pwm_sync_pll_config_bank
  import pwm_cfg_pkg::*;
#(
  parameter int MS_CYCLES = CLK_HZ / MS_PER_S
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Thermal dimming
  input wire logic [7:0] temp_reading_i,
  output logic [11:0] dimming_reduction_o,
  // Headroom comparator
  input wire logic pwm_gen_tick_i,
  input wire logic headroom_cmp_i,
  output logic short_detect_cmp_o,
  output logic boost_down_cmp_o,
  // Supply switch and soft start
  input wire logic fault_recovery_i,
  input wire logic softstart_start_i,
  output logic supply_switch_n_type_o,
  output logic [3:0] supply_switch_current_limit_o,
  output logic [11:0] supply_switch_gate_current_o,
  output logic softstart_busy_o,
  // Frame sync and PLL
  input wire logic frame_sync_i,
  input wire logic pwm_period_tick_i,
  output logic pwm_counter_restart_o,
  output logic phase_det_feedback_o,
  output logic [7:0] pll_slow_coef_o,
  output logic pll_fast_div_o,
  output logic [1:0] pwm_clk_src_o,
  output logic [3:0] pll_multiplier_o,
  output logic sync_is_frame_rate_o
);
  initial begin
    if (MS_CYCLES < 1) $error("MS_CYCLES must be at least one");
    if (MS_CYCLES > 65536) $error("MS_CYCLES exceeds the 16-bit counter");
  end

  // ==========================================================
  // Register file
  logic [7:0] temp_filt_q;
  logic [7:0] pwrline_q;
  logic [7:0] slowdiv_hi_q;
  logic [7:0] sync_ctrl_q;
  logic [7:0] pll_ctrl_q;
  logic [7:0] pll_mode_q;
  logic [7:0] rdata_q;
  logic filt_q;
  logic ss_busy_q;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      temp_filt_q <= RST_TEMP_FILT;
      pwrline_q <= RST_PWRLINE;
      slowdiv_hi_q <= RST_SLOWDIV_HI;
      sync_ctrl_q <= RST_SYNC_CTRL;
      pll_ctrl_q <= RST_PLL_CTRL;
      pll_mode_q <= RST_PLL_MODE;
    end else if (wr_i) begin
      case (addr_i)
        ADDR_TEMP_FILT: temp_filt_q <= wdata_i;
        ADDR_PWRLINE: pwrline_q <= wdata_i;
        ADDR_SLOWDIV_HI: slowdiv_hi_q <= wdata_i;
        ADDR_SYNC_CTRL: sync_ctrl_q <= wdata_i;
        ADDR_PLL_CTRL: pll_ctrl_q <= wdata_i;
        ADDR_PLL_MODE: pll_mode_q <= {3'h0, wdata_i[4], 2'h0, wdata_i[1:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_TEMP_FILT: rdata_q <= temp_filt_q;
        ADDR_PWRLINE: rdata_q <= pwrline_q;
        ADDR_SLOWDIV_HI: rdata_q <= slowdiv_hi_q;
        ADDR_SYNC_CTRL: rdata_q <= sync_ctrl_q;
        ADDR_PLL_CTRL: rdata_q <= pll_ctrl_q;
        ADDR_PLL_MODE: rdata_q <= pll_mode_q;
        ADDR_STATUS: rdata_q <= {6'h00, ss_busy_q, filt_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign rdata_o = rdata_q;

  // Field views
  logic [3:0] gain;
  logic [3:0] filt_sel;
  logic therm_en;
  logic [1:0] ss_sel;
  logic [1:0] ilim_sel;
  logic [1:0] gate_sel;
  logic [12:0] slow_div;
  logic sync_en;
  logic pwm_sync_en;
  logic cnt_rst_en;
  logic [1:0] r_sel;
  logic [3:0] prediv;
  assign gain = temp_filt_q[GAIN_LSB +: 4];
  assign filt_sel = temp_filt_q[FILT_LSB +: 4];
  assign therm_en = pwrline_q[THERM_EN_BIT];
  assign ss_sel = pwrline_q[SS_LSB +: 2];
  assign ilim_sel = pwrline_q[ILIM_LSB +: 2];
  assign gate_sel = pwrline_q[GATE_LSB +: 2];
  assign slow_div = {slowdiv_hi_q, sync_ctrl_q[DIVLO_LSB +: 5]};
  assign sync_en = sync_ctrl_q[SYNC_EN_BIT];
  assign pwm_sync_en = sync_ctrl_q[PWM_SYNC_BIT];
  assign cnt_rst_en = sync_ctrl_q[CNT_RST_BIT];
  assign r_sel = pll_ctrl_q[RSEL_LSB +: 2];
  assign prediv = pll_ctrl_q[PREDIV_LSB +: 4];

  // ==========================================================
  // Thermal dimming and supply switch settings
  logic [11:0] dim_q;
  logic ntype_q;
  logic [3:0] ilim_q;
  logic [11:0] gate_q;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dim_q <= 12'h000;
      ntype_q <= 1'b0;
      ilim_q <= 4'h0;
      gate_q <= 12'h000;
    end else begin
      dim_q <= therm_en ? 12'(gain) * 12'(temp_reading_i) : 12'h000;
      ntype_q <= pwrline_q[NTYPE_BIT];
      ilim_q <= ILIM_A[ilim_sel];
      if (!pwrline_q[NTYPE_BIT]) begin
        gate_q <= GATE_P_UA[gate_sel];
      end else begin
        gate_q <= fault_recovery_i ? GATE_N_UA[gate_sel] : 12'h000;
      end
    end
  end
  assign dimming_reduction_o = dim_q;
  assign supply_switch_n_type_o = ntype_q;
  assign supply_switch_current_limit_o = ilim_q;
  assign supply_switch_gate_current_o = gate_q;

  // ==========================================================
  // Soft-start timer
  logic [15:0] ms_cnt_q;
  logic [5:0] ss_ms_q;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ss_busy_q <= 1'b0;
      ms_cnt_q <= 16'h0000;
      ss_ms_q <= 6'h00;
    end else if (softstart_start_i) begin
      ss_busy_q <= 1'b1;
      ms_cnt_q <= 16'h0000;
      ss_ms_q <= SS_MS[ss_sel];
    end else if (ss_busy_q) begin
      if (32'(ms_cnt_q) == MS_CYCLES - 1) begin
        ms_cnt_q <= 16'h0000;
        ss_ms_q <= ss_ms_q - 6'd1;
        ss_busy_q <= (ss_ms_q != 6'd1);
      end else begin
        ms_cnt_q <= ms_cnt_q + 16'd1;
      end
    end
  end
  assign softstart_busy_o = ss_busy_q;

  // ==========================================================
  // Headroom comparator filter
  logic [8:0] filt_cnt_q;
  logic [8:0] filt_len;
  assign filt_len = FILT_LEN[filt_sel];
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      filt_q <= 1'b0;
      filt_cnt_q <= 9'h000;
    end else if (pwm_gen_tick_i) begin
      if (headroom_cmp_i == filt_q) begin
        filt_cnt_q <= 9'h000;
      end else if (filt_cnt_q >= filt_len - 9'd1) begin
        filt_q <= headroom_cmp_i;
        filt_cnt_q <= 9'h000;
      end else begin
        filt_cnt_q <= filt_cnt_q + 9'd1;
      end
    end
  end
  assign short_detect_cmp_o = filt_q;
  assign boost_down_cmp_o = filt_q;

  // ==========================================================
  // Frame sync pre-divider, counter restart and phase feedback
  logic sync_prev_q;
  logic [3:0] pre_cnt_q;
  logic restart_q;
  logic [12:0] fb_cnt_q;
  logic fb_q;
  logic sync_rise;
  assign sync_rise = sync_en && frame_sync_i && !sync_prev_q;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync_prev_q <= 1'b0;
      pre_cnt_q <= 4'h0;
      restart_q <= 1'b0;
    end else begin
      sync_prev_q <= frame_sync_i;
      restart_q <= 1'b0;
      if (!sync_en) begin
        pre_cnt_q <= 4'h0;
      end else if (sync_rise) begin
        if (pre_cnt_q >= prediv) begin
          pre_cnt_q <= 4'h0;
          restart_q <= cnt_rst_en;
        end else begin
          pre_cnt_q <= pre_cnt_q + 4'd1;
        end
      end
    end
  end
  assign pwm_counter_restart_o = restart_q;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fb_cnt_q <= 13'h0000;
      fb_q <= 1'b0;
    end else begin
      fb_q <= 1'b0;
      if (!pwm_sync_en) begin
        fb_cnt_q <= 13'h0000;
      end else if (pwm_period_tick_i) begin
        if ({1'b0, fb_cnt_q} + 14'd1 >= {1'b0, slow_div}) begin
          fb_cnt_q <= 13'h0000;
          fb_q <= 1'b1;
        end else begin
          fb_cnt_q <= fb_cnt_q + 13'd1;
        end
      end
    end
  end
  assign phase_det_feedback_o = fb_q;

  // ==========================================================
  // PLL configuration
  logic [7:0] coef_q;
  logic fast_q;
  logic [1:0] src_q;
  logic [3:0] mult_q;
  logic frame_rate_q;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      coef_q <= 8'h10;
      fast_q <= 1'b0;
      src_q <= SRC_OSC;
      mult_q <= 4'h1;
      frame_rate_q <= 1'b0;
    end else begin
      coef_q <= 8'h10 << r_sel;
      fast_q <= pll_ctrl_q[SEL_DIV_BIT];
      if (!pll_ctrl_q[PLL_EN_BIT]) begin
        src_q <= SRC_OSC;
      end else begin
        src_q <= sync_en ? SRC_PLL_SYNC : SRC_PLL_OSC;
      end
      mult_q <= 4'h1 << pll_mode_q[RES_LSB +: 2];
      frame_rate_q <= pll_mode_q[SYNC_TYPE_BIT];
    end
  end
  assign pll_slow_coef_o = coef_q;
  assign pll_fast_div_o = fast_q;
  assign pwm_clk_src_o = src_q;
  assign pll_multiplier_o = mult_q;
  assign sync_is_frame_rate_o = frame_rate_q;

  // ==========================================================
  // Checks
  property p_filt_persist;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    filt_q != $past(filt_q) |->
      $past(pwm_gen_tick_i && filt_cnt_q >= filt_len - 9'd1);
  endproperty
  a_filt_persist: assert property (p_filt_persist)
    else $error("Filter output changed before its length elapsed");

  property p_filt_outputs;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    short_detect_cmp_o == filt_q && boost_down_cmp_o == filt_q;
  endproperty
  a_filt_outputs: assert property (p_filt_outputs)
    else $error("Comparator users not fed from filtered state");

  property p_sync_ignored;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    !sync_en |=> !restart_q;
  endproperty
  a_sync_ignored: assert property (p_sync_ignored)
    else $error("Restart seen while frame sync disabled");

  property p_restart_cause;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    restart_q |-> $past(sync_rise && cnt_rst_en && pre_cnt_q >= prediv);
  endproperty
  a_restart_cause: assert property (p_restart_cause)
    else $error("Counter restart without qualified sync edge");

  property p_fb_cause;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    fb_q |-> $past(pwm_sync_en && pwm_period_tick_i);
  endproperty
  a_fb_cause: assert property (p_fb_cause)
    else $error("Phase feedback pulse without sync and period tick");

  property p_coef;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    $stable(r_sel) |=> pll_slow_coef_o == (8'h10 << $past(r_sel));
  endproperty
  a_coef: assert property (p_coef)
    else $error("Slow divider coefficient mismatch");

  property p_gate_off;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    pwrline_q[NTYPE_BIT] && !fault_recovery_i |=>
      supply_switch_gate_current_o == 12'h000;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("n-type gate current outside fault recovery");

  property p_pll_off;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    !pll_ctrl_q[PLL_EN_BIT] |=> pwm_clk_src_o == SRC_OSC;
  endproperty
  a_pll_off: assert property (p_pll_off)
    else $error("PLL disabled but oscillator not selected");

  property p_ss_start;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
    softstart_start_i |=> ss_busy_q && ss_ms_q == SS_MS[$past(ss_sel)];
  endproperty
  a_ss_start: assert property (p_ss_start)
    else $error("Soft-start duration not loaded");
endmodule : pwm_sync_pll_config_bank
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the PWM sync, PLL and supply switch bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pwm_cfg_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic fr;
    logic [7:0] rexp;
    logic [16:0] sw;
    logic [15:0] pl;
  } row_t;
  localparam int MS_CYC = 4;
  localparam logic [15:0] PL0 = {8'd16, 1'b0, 2'b00, 4'd1, 1'b0};
  localparam logic [15:0] PLF = {8'd128, 1'b1, 2'b01, 4'd1, 1'b0};
  localparam logic [15:0] PLM = {8'd16, 1'b0, 2'b00, 4'd4, 1'b1};
  localparam logic [16:0] SWF = {1'b1, 4'd8, 12'd0};
  logic clk_sys_i, arst_n_i, wr_i, rd_i, pwm_gen_tick_i, headroom_cmp_i;
  logic fault_recovery_i, softstart_start_i, frame_sync_i, pwm_period_tick_i;
  logic [7:0] addr_i, wdata_i, rdata_o, temp_reading_i, pll_slow_coef_o;
  logic [11:0] dimming_reduction_o, supply_switch_gate_current_o;
  logic [3:0] supply_switch_current_limit_o, pll_multiplier_o;
  logic [1:0] pwm_clk_src_o;
  logic short_detect_cmp_o, boost_down_cmp_o, supply_switch_n_type_o;
  logic softstart_busy_o, pwm_counter_restart_o, phase_det_feedback_o;
  logic pll_fast_div_o, sync_is_frame_rate_o;
  int bad_count = 0;
  int comparisons = 0;
  logic [7:0] addr_tab [6] = '{8'h69, 8'h6a, 8'h6b, 8'h6c, 8'h6d, 8'h70};
  logic [7:0] pre_tab [2] = '{8'h01, 8'h0f};
  int ss_ms [4] = '{5, 10, 20, 50};
  row_t rows [21] = '{
    '{8'h6a, 8'h00, 1'b0, 8'h00, {1'b0, 4'd0, 12'd55}, PL0},
    '{8'h6a, 8'h05, 1'b1, 8'h05, {1'b0, 4'd0, 12'd110}, PL0},
    '{8'h6a, 8'h0a, 1'b0, 8'h0a, {1'b0, 4'd6, 12'd220}, PL0},
    '{8'h6a, 8'h0f, 1'b0, 8'h0f, {1'b0, 4'd8, 12'd440}, PL0},
    '{8'h6a, 8'h40, 1'b0, 8'h40, {1'b1, 4'd0, 12'd0}, PL0},
    '{8'h6a, 8'h40, 1'b1, 8'h40, {1'b1, 4'd0, 12'd300}, PL0},
    '{8'h6a, 8'h45, 1'b1, 8'h45, {1'b1, 4'd0, 12'd500}, PL0},
    '{8'h6a, 8'h4a, 1'b1, 8'h4a, {1'b1, 4'd6, 12'd1000}, PL0},
    '{8'h6a, 8'h4f, 1'b1, 8'h4f, {1'b1, 4'd8, 12'd2200}, PL0},
    '{8'h6a, 8'h4f, 1'b0, 8'h4f, SWF, PL0},
    '{8'h6d, 8'h50, 1'b0, 8'h50, SWF, {8'd32, 1'b0, 2'b01, 4'd1, 1'b0}},
    '{8'h6d, 8'ha0, 1'b0, 8'ha0, SWF, {8'd64, 1'b1, 2'b00, 4'd1, 1'b0}},
    '{8'h6d, 8'hf0, 1'b0, 8'hf0, SWF, PLF},
    '{8'h6c, 8'h80, 1'b0, 8'h80, SWF, {8'd128, 1'b1, 2'b10, 4'd1, 1'b0}},
    '{8'h6c, 8'h00, 1'b0, 8'h00, SWF, PLF},
    '{8'h70, 8'hff, 1'b0, 8'h13, SWF, {8'd128, 1'b1, 2'b01, 4'd8, 1'b1}},
    '{8'h70, 8'h01, 1'b0, 8'h01, SWF, {8'd128, 1'b1, 2'b01, 4'd2, 1'b0}},
    '{8'h70, 8'h12, 1'b0, 8'h12, SWF, {8'd128, 1'b1, 2'b01, 4'd4, 1'b1}},
    '{8'h6d, 8'h00, 1'b0, 8'h00, SWF, PLM},
    '{8'h80, 8'hff, 1'b0, 8'h00, SWF, PLM},
    '{8'h71, 8'hff, 1'b0, 8'h00, SWF, PLM}};
  wire [16:0] sw_obs = {supply_switch_n_type_o,
    supply_switch_current_limit_o, supply_switch_gate_current_o};
  wire [15:0] pl_obs = {pll_slow_coef_o, pll_fast_div_o, pwm_clk_src_o,
    pll_multiplier_o, sync_is_frame_rate_o};

  pwm_sync_pll_config_bank #(.MS_CYCLES(MS_CYC)) u_pwm_sync_pll_config_bank (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .temp_reading_i(temp_reading_i),
    .dimming_reduction_o(dimming_reduction_o),
    .pwm_gen_tick_i(pwm_gen_tick_i), .headroom_cmp_i(headroom_cmp_i),
    .short_detect_cmp_o(short_detect_cmp_o),
    .boost_down_cmp_o(boost_down_cmp_o),
    .fault_recovery_i(fault_recovery_i),
    .softstart_start_i(softstart_start_i),
    .supply_switch_n_type_o(supply_switch_n_type_o),
    .supply_switch_current_limit_o(supply_switch_current_limit_o),
    .supply_switch_gate_current_o(supply_switch_gate_current_o),
    .softstart_busy_o(softstart_busy_o), .frame_sync_i(frame_sync_i),
    .pwm_period_tick_i(pwm_period_tick_i),
    .pwm_counter_restart_o(pwm_counter_restart_o),
    .phase_det_feedback_o(phase_det_feedback_o),
    .pll_slow_coef_o(pll_slow_coef_o), .pll_fast_div_o(pll_fast_div_o),
    .pwm_clk_src_o(pwm_clk_src_o), .pll_multiplier_o(pll_multiplier_o),
    .sync_is_frame_rate_o(sync_is_frame_rate_o));

  // ==========
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  // Write, then one idle cycle so strobes never toggle twice in a step
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask : reg_rd

  task automatic tick(input logic raw, input logic exp);
    headroom_cmp_i <= raw;
    pwm_gen_tick_i <= 1'b1;
    @(posedge clk_sys_i);
    pwm_gen_tick_i <= 1'b0;
    #1;
    chk(short_detect_cmp_o, exp);
    chk(boost_down_cmp_o, exp);
    @(posedge clk_sys_i);
  endtask : tick

  // cnt sync edges or period ticks; counts the resulting pulses after each
  task automatic run_pulses(input logic sel, input int per, input int cnt);
    logic [3:0] n;
    for (int k = 0; k < cnt; k++) begin
      n = 4'h0;
      if (sel) frame_sync_i <= 1'b1;
      else pwm_period_tick_i <= 1'b1;
      @(posedge clk_sys_i);
      frame_sync_i <= 1'b0;
      pwm_period_tick_i <= 1'b0;
      repeat (3) begin
        #1;
        n = n + (sel ? pwm_counter_restart_o : phase_det_feedback_o);
        @(posedge clk_sys_i);
      end
      @(posedge clk_sys_i);
      chk(n, (per != 0 && k % per == per - 1));
    end
  endtask : run_pulses

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    #1_000_000;
    bad_count++;
    end_sim();
  end

  // ==========
  // Main sequence
  initial begin
    logic [7:0] d;
    int cnt;
    arst_n_i = 1'b0;
    {wr_i, rd_i, pwm_gen_tick_i, headroom_cmp_i, fault_recovery_i} = '0;
    {softstart_start_i, frame_sync_i, pwm_period_tick_i} = '0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    temp_reading_i = 8'hff;
    repeat (8) @(posedge clk_sys_i);
    #1;
    chk(pl_obs, PL0);
    chk(supply_switch_gate_current_o, 12'h000);
    @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    foreach (addr_tab[i]) begin
      reg_rd(addr_tab[i], d);
      chk(d, 8'h00);
      @(posedge clk_sys_i);
    end
    foreach (rows[i]) begin
      fault_recovery_i <= rows[i].fr;
      reg_wr(rows[i].addr, rows[i].wdata);
      reg_rd(rows[i].addr, d);
      chk(d, rows[i].rexp);
      chk(sw_obs, rows[i].sw);
      chk(pl_obs, rows[i].pl);
      @(posedge clk_sys_i);
    end
    // Filter: interrupted run, shortest and longest lengths
    reg_wr(ADDR_TEMP_FILT, 8'h00);
    repeat (3) tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
    repeat (4) tick(1'b1, 1'b0);
    tick(1'b1, 1'b1);
    reg_rd(ADDR_STATUS, d);
    chk(d, 8'h01);
    @(posedge clk_sys_i);
    reg_wr(ADDR_TEMP_FILT, 8'h0f);
    for (int k = 0; k < 460; k++) tick(1'b0, k < 459);
    // Frame sync pre-divider, counter reset and enable
    foreach (pre_tab[j]) begin
      reg_wr(ADDR_SYNC_CTRL, 8'h00);
      reg_wr(ADDR_PLL_CTRL, pre_tab[j]);
      reg_wr(ADDR_SYNC_CTRL, 8'ha0);
      run_pulses(1'b1, pre_tab[j] + 1, 2 * (pre_tab[j] + 1));
    end
    reg_wr(ADDR_SYNC_CTRL, 8'h80);
    run_pulses(1'b1, 0, 2);
    reg_wr(ADDR_SYNC_CTRL, 8'h20);
    run_pulses(1'b1, 0, 2);
    // Phase detector feedback through the slow divider
    reg_wr(ADDR_SYNC_CTRL, 8'h00);
    reg_wr(ADDR_SLOWDIV_HI, 8'h01);
    reg_wr(ADDR_SYNC_CTRL, 8'h40);
    run_pulses(1'b0, 32, 32);
    reg_wr(ADDR_SLOWDIV_HI, 8'h00);
    reg_wr(ADDR_SYNC_CTRL, 8'h42);
    run_pulses(1'b0, 2, 4);
    reg_wr(ADDR_SYNC_CTRL, 8'h02);
    run_pulses(1'b0, 0, 2);
    // Soft-start duration for every code
    for (int c = 0; c < 4; c++) begin
      reg_wr(ADDR_PWRLINE, {2'b00, c[1:0], 4'h0});
      softstart_start_i <= 1'b1;
      @(posedge clk_sys_i);
      softstart_start_i <= 1'b0;
      cnt = 0;
      repeat (250) begin
        #1;
        if (softstart_busy_o === 1'b1) cnt++;
        @(posedge clk_sys_i);
      end
      chk(cnt, ss_ms[c] * MS_CYC);
    end
    // Thermal dimming gain, off then on
    reg_wr(ADDR_TEMP_FILT, 8'hf0);
    #1;
    chk(dimming_reduction_o, 12'h000);
    @(posedge clk_sys_i);
    reg_wr(ADDR_PWRLINE, 8'h80);
    #1;
    chk(dimming_reduction_o, 12'hef1);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
